// ### common/msd_params.svh
// Constants of the memory space decoder: addresses, field positions, reset values.
`ifndef MSD_PARAMS_SVH
`define MSD_PARAMS_SVH

`define MSD_SYSCTL_ADDR      8'hB1
`define MSD_SYSCTL_MAP_BIT   0
`define MSD_SYSCTL_AUXEN_BIT 1
`define MSD_SYSCTL_EA_BIT    7
`define MSD_SYSCTL_MAP_RST   1'b0
`define MSD_SYSCTL_AUXEN_RST 1'b1

`define MSD_SFR_BASE         8'h80
`define MSD_BITAREA_BASE     8'h20
`define MSD_BANK_LO_BIT      3
`define MSD_BANK_HI_BIT      4

`define MSD_ACC_ADDR         8'hE0
`define MSD_B_ADDR           8'hF0
`define MSD_PSW_ADDR         8'hD0
`define MSD_SP_ADDR          8'h81
`define MSD_DPL_ADDR         8'h82
`define MSD_DPH_ADDR         8'h83

`define MSD_PROG_LIMIT       16'h1FFF
`define MSD_AUX_SIZE         256
`define MSD_ADDR_SPACE       17'h10000

`endif

// ### common/msd_pkg.sv
// Types shared by the memory space decoder and its users.
package msd_pkg;

   typedef enum logic [2:0] {
      MODE_DIRECT   = 3'b000,
      MODE_INDIRECT = 3'b001,
      MODE_REGISTER = 3'b010,
      MODE_BIT      = 3'b011,
      MODE_XDPTR    = 3'b100,
      MODE_XPTR8    = 3'b101
   } msd_mode_e;

   typedef enum logic [2:0] {
      TGT_NONE    = 3'b000,
      TGT_LOWER   = 3'b001,
      TGT_UPPER   = 3'b010,
      TGT_SFR_STD = 3'b011,
      TGT_SFR_MAP = 3'b100,
      TGT_AUX     = 3'b101,
      TGT_EXT     = 3'b110
   } msd_target_e;

   typedef struct packed {
      logic        valid;
      msd_mode_e   mode;
      logic [7:0]  operand;
      logic        write;
      logic [7:0]  wdata;
   } msd_req_s;

   typedef struct packed {
      logic [7:0]  program_status_word;
      logic [7:0]  ptr0;
      logic [7:0]  ptr1;
      logic [15:0] data_pointer_16;
      logic [7:0]  page_high;
   } msd_core_s;

   typedef struct packed {
      logic        valid;
      msd_target_e target;
      logic [15:0] addr;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic        write;
   } msd_rsp_s;

   typedef struct packed {
      logic        valid;
      logic        ext;
      logic [15:0] addr;
   } msd_fetch_s;

   typedef struct packed {
      logic        ea_meta;
      logic        ea_sync;
      logic        map_sel;
      logic        aux_en;
      msd_fetch_s  fetch;
      msd_rsp_s    rsp;
      logic        sysctl_hit;
      logic [7:0]  sysctl_rdata;
   } msd_state_s;

endpackage : msd_pkg

// ### rtl/msd_decoder.sv
// Address space decoder: program fetch source and data access routing.
//
// Overview of operation
// - External access pin low: every instruction fetch goes to external program memory.
// - Pin high: fetch internally, externally once the address exceeds the internal limit.
// - Return to internal fetching as soon as the address is back below the limit.
// - Internal data uses 8-bit addresses; external and auxiliary RAM 8 or 16 bits.
// - Reset leaves internal and auxiliary RAM contents untouched.
// - Auxiliary RAM contents are kept in every power-saving mode.
// - Lower RAM 00 to 7F is served for direct and indirect addressing.
// - Bit addresses 00 to 7F map to bytes 20 to 2F, bit 0 first.
// - Lowest 32 bytes form four banks of eight registers, one active.
// - From 80 to FF, indirect goes to upper RAM, direct to special registers.
// - Special registers at addresses with bits 0-2 zero are bit-addressable.
// - Auxiliary RAM sits at the top of external data space, via external moves.
// - Auxiliary RAM disabled: its address range goes to external data memory.
// - External moves use the 16-bit data pointer or pointer register zero/one.
// - Map-select clear after reset: standard area; set: mapped register area.
// - Map-select is cleared by hardware only at reset; software sets and clears it.
// - Core registers such as the accumulator ignore the map-select bit on direct access; bit access to their bits 1-7 follows it.
// - The mapped area offers the same byte and bit addressing as the standard one.
// - Status word bits 3 and 4 select the active register bank.
// - Indirect addresses come from pointer register zero or one of the active bank.
// - Bank values 00, 01, 10, 11 select 00-07, 08-0F, 10-17, 18-1F.
`timescale 1ns/10ps
`include "msd_params.svh"

module msd_decoder #(
   parameter logic [15:0] PROG_LIMIT     = `MSD_PROG_LIMIT,
   parameter int          AUX_RAM_SIZE   = `MSD_AUX_SIZE,
   parameter bit          AUX_PRESENT    = 1'b1,
   parameter bit          MAPPED_PRESENT = 1'b1
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   // Device pin
   input  wire logic                external_access_select,
   // Instruction fetch from the core
   input  wire logic                fetch_valid,
   input  wire logic [15:0]         fetch_addr,
   // Data access from the core
   input  wire msd_pkg::msd_req_s   data_req,
   input  wire msd_pkg::msd_core_s  core_regs,
   // Fetch routing
   output logic                     fetch_out_valid,
   output logic                     fetch_external,
   output logic [15:0]              fetch_out_addr,
   // Data routing
   output msd_pkg::msd_rsp_s        data_rsp,
   // System control read-back
   output logic                     sysctl_hit,
   output logic [7:0]               sysctl_rdata
);

   // Lowest address of the auxiliary RAM at the top of the 64 Kbyte space.
   localparam logic [16:0] AUX_BASE = 17'(`MSD_ADDR_SPACE - 17'(AUX_RAM_SIZE));

   msd_pkg::msd_state_s state_r;
   msd_pkg::msd_state_s state_nxt;

   logic [1:0]  bank;
   logic [7:0]  ptr_val;
   logic        core_reg;
   logic        sfr_mapped;
   logic [15:0] x_addr;
   logic        sysctl_wr;

   // Registers that stay in the standard area on direct access whatever the map-select bit says.
   function automatic logic is_core_reg(input logic [7:0] a);
      logic r;
      r = 1'b0;
      case (a)
         `MSD_ACC_ADDR,
         `MSD_B_ADDR,
         `MSD_PSW_ADDR,
         `MSD_SP_ADDR,
         `MSD_DPL_ADDR,
         `MSD_DPH_ADDR,
         `MSD_SYSCTL_ADDR: r = 1'b1;
         default:          r = 1'b0;
      endcase
      return r;
   endfunction : is_core_reg

   always_comb begin
      bank = {core_regs.program_status_word[`MSD_BANK_HI_BIT], core_regs.program_status_word[`MSD_BANK_LO_BIT]};
      ptr_val = data_req.operand[0] ? core_regs.ptr1 : core_regs.ptr0;
      core_reg = is_core_reg(data_req.operand);
      sfr_mapped = MAPPED_PRESENT && state_r.map_sel && !core_reg;
      if (data_req.mode == msd_pkg::MODE_XDPTR) begin
         x_addr = core_regs.data_pointer_16;
      end else begin
         x_addr = {core_regs.page_high, ptr_val};
      end
      sysctl_wr = data_req.valid && data_req.write
                  && data_req.mode == msd_pkg::MODE_DIRECT
                  && data_req.operand == `MSD_SYSCTL_ADDR;
   end

   always_comb begin
      state_nxt = state_r;

      // Pin synchroniser; only the second stage is used by the decode.
      state_nxt.ea_meta = external_access_select;
      state_nxt.ea_sync = state_r.ea_meta;

      // Fetch source is re-evaluated on every fetch, so it returns to internal
      // memory as soon as the address drops back under the limit.
      state_nxt.fetch.valid = fetch_valid;
      state_nxt.fetch.addr  = fetch_addr;
      if (!state_r.ea_sync) begin
         state_nxt.fetch.ext = 1'b1;
      end else if (fetch_addr > PROG_LIMIT) begin
         state_nxt.fetch.ext = 1'b1;
      end else begin
         state_nxt.fetch.ext = 1'b0;
      end

      // Apart from reset, the map-select bit changes only on a software write.
      if (sysctl_wr) begin
         state_nxt.map_sel = data_req.wdata[`MSD_SYSCTL_MAP_BIT];
         state_nxt.aux_en  = data_req.wdata[`MSD_SYSCTL_AUXEN_BIT];
      end

      state_nxt.sysctl_hit = data_req.valid && !data_req.write
                             && data_req.mode == msd_pkg::MODE_DIRECT
                             && data_req.operand == `MSD_SYSCTL_ADDR;
      state_nxt.sysctl_rdata = 8'h00;
      state_nxt.sysctl_rdata[`MSD_SYSCTL_MAP_BIT]   = state_r.map_sel;
      state_nxt.sysctl_rdata[`MSD_SYSCTL_AUXEN_BIT] = state_r.aux_en;
      state_nxt.sysctl_rdata[`MSD_SYSCTL_EA_BIT]    = state_r.ea_sync;

      state_nxt.rsp.valid   = data_req.valid;
      state_nxt.rsp.write   = data_req.write;
      state_nxt.rsp.bit_op  = 1'b0;
      state_nxt.rsp.bit_sel = 3'h0;
      state_nxt.rsp.target  = msd_pkg::TGT_NONE;
      state_nxt.rsp.addr    = 16'h0000;

      case (data_req.mode)
         msd_pkg::MODE_DIRECT: begin
            state_nxt.rsp.addr = {8'h00, data_req.operand};
            if (data_req.operand < `MSD_SFR_BASE) begin
               state_nxt.rsp.target = msd_pkg::TGT_LOWER;
            end else if (sfr_mapped) begin
               state_nxt.rsp.target = msd_pkg::TGT_SFR_MAP;
            end else begin
               state_nxt.rsp.target = msd_pkg::TGT_SFR_STD;
            end
         end
         msd_pkg::MODE_INDIRECT: begin
            state_nxt.rsp.addr = {8'h00, ptr_val};
            if (ptr_val < `MSD_SFR_BASE) begin
               state_nxt.rsp.target = msd_pkg::TGT_LOWER;
            end else begin
               state_nxt.rsp.target = msd_pkg::TGT_UPPER;
            end
         end
         msd_pkg::MODE_REGISTER: begin
            // Bank n occupies bytes 8n to 8n+7 of lower RAM.
            state_nxt.rsp.addr = {8'h00, 3'b000, bank, data_req.operand[2:0]};
            state_nxt.rsp.target = msd_pkg::TGT_LOWER;
         end
         msd_pkg::MODE_BIT: begin
            state_nxt.rsp.bit_op  = 1'b1;
            state_nxt.rsp.bit_sel = data_req.operand[2:0];
            if (data_req.operand < `MSD_SFR_BASE) begin
               state_nxt.rsp.addr = {8'h00, `MSD_BITAREA_BASE
                                     + {4'h0, data_req.operand[6:3]}};
               state_nxt.rsp.target = msd_pkg::TGT_LOWER;
            end else begin
               state_nxt.rsp.addr = {8'h00, data_req.operand[7:3], 3'b000};
               if (sfr_mapped) begin
                  state_nxt.rsp.target = msd_pkg::TGT_SFR_MAP;
               end else begin
                  state_nxt.rsp.target = msd_pkg::TGT_SFR_STD;
               end
            end
         end
         msd_pkg::MODE_XDPTR,
         msd_pkg::MODE_XPTR8: begin
            state_nxt.rsp.addr = x_addr;
            if (AUX_PRESENT && state_r.aux_en && {1'b0, x_addr} >= AUX_BASE) begin
               state_nxt.rsp.target = msd_pkg::TGT_AUX;
            end else begin
               state_nxt.rsp.target = msd_pkg::TGT_EXT;
            end
         end
         default: begin
            state_nxt.rsp.valid = 1'b0;
         end
      endcase
   end

   // Only control state is reset; the RAMs this block routes to have no clear
   // path here, so their contents survive reset and power-saving modes.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_r.ea_meta      <= 1'b0;
         state_r.ea_sync      <= 1'b0;
         state_r.map_sel      <= `MSD_SYSCTL_MAP_RST;
         state_r.aux_en       <= `MSD_SYSCTL_AUXEN_RST;
         state_r.fetch        <= '0;
         state_r.rsp          <= '0;
         state_r.sysctl_hit   <= 1'b0;
         state_r.sysctl_rdata <= 8'h00;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign fetch_out_valid = state_r.fetch.valid;
   assign fetch_external  = state_r.fetch.ext;
   assign fetch_out_addr  = state_r.fetch.addr;
   assign data_rsp        = state_r.rsp;
   assign sysctl_hit      = state_r.sysctl_hit;
   assign sysctl_rdata    = state_r.sysctl_rdata;

endmodule : msd_decoder

// ### bench/msd_core_model.sv
// CPU core model: status word, data pointer and the pointer registers of the active bank.
`timescale 1ns/10ps
module msd_core_model (
   // Core state set by the bench
   input  wire logic [7:0]    program_status_word,
   input  wire logic [15:0]   data_pointer_16,
   input  wire logic [7:0]    page_high,
   // Register view towards the decoder
   output msd_pkg::msd_core_s core_regs
);
   // Entry i holds i*8, so the pointers of the upper banks reach upper RAM.
   logic [7:0] rf [32];
   initial for (int i = 0; i < 32; i++) rf[i] = 8'(i * 8);
   assign core_regs = '{program_status_word, rf[{program_status_word[4:3], 3'h0}], rf[{program_status_word[4:3], 3'h1}],
                        data_pointer_16, page_high};
endmodule : msd_core_model

// ### bench/msd_properties.sv
// Assertions on the ports of the memory space decoder.
`timescale 1ns/10ps
module msd_properties #(
   parameter logic [15:0] PROG_LIMIT   = 16'h1FFF,
   parameter int          AUX_RAM_SIZE = 256
) (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               resetn,
   // Requests
   input wire logic               external_access_select,
   input wire logic               fetch_valid,
   input wire logic [15:0]        fetch_addr,
   input wire msd_pkg::msd_req_s  data_req,
   input wire msd_pkg::msd_core_s core_regs,
   // Answers
   input wire logic               fetch_out_valid,
   input wire logic               fetch_external,
   input wire logic [15:0]        fetch_out_addr,
   input wire msd_pkg::msd_rsp_s  data_rsp,
   input wire logic               sysctl_hit,
   input wire logic [7:0]         sysctl_rdata
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   logic               dv;
   msd_pkg::msd_mode_e md;
   assign dv = data_req.valid;
   assign md = data_req.mode;
   property p_pin_low;
      (!external_access_select) [*3] ##0 fetch_valid |=> fetch_out_valid && fetch_external;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("fetch not external, pin low");
   property p_internal;
      external_access_select [*3] ##0 (fetch_valid && fetch_addr <= PROG_LIMIT)
         |=> fetch_out_valid && !fetch_external;
   endproperty
   a_internal: assert property (p_internal) else $error("fetch not internal");
   property p_above;
      fetch_valid && fetch_addr > PROG_LIMIT
         |=> fetch_out_valid && fetch_external && fetch_out_addr == $past(fetch_addr);
   endproperty
   a_above: assert property (p_above) else $error("fetch above limit not external");
   property p_bit_low;
      dv && md == msd_pkg::MODE_BIT && !data_req.operand[7] |=> data_rsp.bit_op
         && data_rsp.addr == 16'h0020 + $past(data_req.operand[6:3])
         && data_rsp.bit_sel == $past(data_req.operand[2:0]);
   endproperty
   a_bit_low: assert property (p_bit_low) else $error("bad lower bit address");
   property p_reg;
      dv && md == msd_pkg::MODE_REGISTER |=> data_rsp.target == msd_pkg::TGT_LOWER
         && data_rsp.addr == {11'h000, $past(core_regs.program_status_word[4:3]), $past(data_req.operand[2:0])};
   endproperty
   a_reg: assert property (p_reg) else $error("bad register address");
   property p_indirect;
      dv && md == msd_pkg::MODE_INDIRECT |=> data_rsp.target == (data_rsp.addr[7] ?
         msd_pkg::TGT_UPPER : msd_pkg::TGT_LOWER) && data_rsp.addr ==
         {8'h00, $past(data_req.operand[0] ? core_regs.ptr1 : core_regs.ptr0)};
   endproperty
   a_indirect: assert property (p_indirect) else $error("bad indirect route");
   property p_core_reg;
      dv && md == msd_pkg::MODE_DIRECT && data_req.operand == 8'hE0
         |=> data_rsp.valid && data_rsp.target == msd_pkg::TGT_SFR_STD;
   endproperty
   a_core_reg: assert property (p_core_reg) else $error("core register mapped");
   property p_xdptr;
      dv && md == msd_pkg::MODE_XDPTR |=> data_rsp.addr == $past(core_regs.data_pointer_16)
         && (int'(data_rsp.addr) < 65536 - AUX_RAM_SIZE ? data_rsp.target == msd_pkg::TGT_EXT
         : data_rsp.target inside {msd_pkg::TGT_AUX, msd_pkg::TGT_EXT});
   endproperty
   a_xdptr: assert property (p_xdptr) else $error("bad external move route");
endmodule : msd_properties

bind msd_decoder msd_properties #(.PROG_LIMIT(PROG_LIMIT), .AUX_RAM_SIZE(AUX_RAM_SIZE)) u_props (
   .ref_clk, .resetn, .external_access_select, .fetch_valid, .fetch_addr, .data_req, .core_regs,
   .fetch_out_valid, .fetch_external, .fetch_out_addr, .data_rsp, .sysctl_hit, .sysctl_rdata);

// ### bench/testbench.sv
// Self-checking bench for the memory space decoder.
`timescale 1ns/10ps
module testbench;
   logic               ref_clk = 1'b0;
   logic               resetn = 1'b0;
   logic               pin = 1'b0;
   logic               fv = 1'b0;
   logic [15:0]        fa = 16'h0000;
   msd_pkg::msd_req_s  rq = '0;
   logic [7:0]         program_status_word = 8'h00;
   logic [15:0]        data_pointer_16 = 16'h0000;
   msd_pkg::msd_core_s cr;
   logic               fov, fext, hit;
   logic [15:0]        foa;
   msd_pkg::msd_rsp_s  rsp;
   logic [7:0]         rd;
   int                 err_count = 0;
   int                 n_compared = 0;
   int                 cyc = 0;
   msd_core_model u_core (.program_status_word(program_status_word), .data_pointer_16(data_pointer_16), .page_high(8'hFF), .core_regs(cr));
   msd_decoder #(.PROG_LIMIT(16'h1FFF), .AUX_RAM_SIZE(256)) u_dut (
      .ref_clk(ref_clk), .resetn(resetn), .external_access_select(pin),
      .fetch_valid(fv), .fetch_addr(fa), .data_req(rq), .core_regs(cr),
      .fetch_out_valid(fov), .fetch_external(fext), .fetch_out_addr(foa),
      .data_rsp(rsp), .sysctl_hit(hit), .sysctl_rdata(rd));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic fch(input logic [15:0] a, input logic ext);
      @(negedge ref_clk);
      fv = 1'b1;
      fa = a;
      @(negedge ref_clk);
      fv = 1'b0;
      chk("fetch", {14'h0, fov, fext}, {14'h0, 1'b1, ext});
      chk("fetch_out_addr", foa, a);
   endtask : fch
   task automatic acc(input msd_pkg::msd_mode_e m, input logic [7:0] op,
                      input msd_pkg::msd_target_e t, input logic [15:0] a,
                      input logic [8:0] w = 9'h000);
      @(negedge ref_clk);
      rq = '{1'b1, m, op, w[8], w[7:0]};
      @(negedge ref_clk);
      rq.valid = 1'b0;
      chk("rsp_valid", {15'h0, rsp.valid}, 16'h0001);
      chk("rsp_target", {13'h0, rsp.target}, {13'h0, t});
      chk("rsp_addr", rsp.addr, a);
      chk("rsp_write_bit", {14'h0, rsp.write, rsp.bit_op}, {14'h0, w[8], m == msd_pkg::MODE_BIT});
   endtask : acc
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      resetn = 1'b1;
      fch(16'h0000, 1'b1);
      fch(16'h1FFE, 1'b1);
      pin = 1'b1;
      repeat (3) @(negedge ref_clk);
      fch(16'h0000, 1'b0);
      fch(16'h1FFF, 1'b0);
      fch(16'h2000, 1'b1);
      fch(16'h1FFE, 1'b0);
      for (int b = 0; b < 4; b++) begin
         program_status_word = 8'(b << 3);
         acc(msd_pkg::MODE_REGISTER, 8'h05, msd_pkg::TGT_LOWER, 16'(b*8+5));
         acc(msd_pkg::MODE_INDIRECT, 8'h01, b > 1 ? msd_pkg::TGT_UPPER : msd_pkg::TGT_LOWER,
             16'(b * 64 + 8));
      end
      program_status_word = 8'h00;
      acc(msd_pkg::MODE_DIRECT, 8'h30, msd_pkg::TGT_LOWER, 16'h0030);
      acc(msd_pkg::MODE_BIT, 8'h00, msd_pkg::TGT_LOWER, 16'h0020);
      acc(msd_pkg::MODE_BIT, 8'h7F, msd_pkg::TGT_LOWER, 16'h002F);
      chk("bit_sel", {13'h0, rsp.bit_sel}, 16'h0007);
      acc(msd_pkg::MODE_BIT, 8'h87, msd_pkg::TGT_SFR_STD, 16'h0080);
      acc(msd_pkg::MODE_DIRECT, 8'h90, msd_pkg::TGT_SFR_STD, 16'h0090);
      acc(msd_pkg::MODE_DIRECT, 8'hB1, msd_pkg::TGT_SFR_STD, 16'h00B1);
      chk("system_control", {7'h0, hit, rd}, 16'h0182);
      acc(msd_pkg::MODE_DIRECT, 8'hB1, msd_pkg::TGT_SFR_STD, 16'h00B1, 9'h103);
      acc(msd_pkg::MODE_DIRECT, 8'h90, msd_pkg::TGT_SFR_MAP, 16'h0090);
      acc(msd_pkg::MODE_BIT, 8'h93, msd_pkg::TGT_SFR_MAP, 16'h0090);
      acc(msd_pkg::MODE_DIRECT, 8'hE0, msd_pkg::TGT_SFR_STD, 16'h00E0);
      repeat (20) @(negedge ref_clk);
      acc(msd_pkg::MODE_DIRECT, 8'hA8, msd_pkg::TGT_SFR_MAP, 16'h00A8);
      data_pointer_16 = 16'hFF10;
      acc(msd_pkg::MODE_XDPTR, 8'h00, msd_pkg::TGT_AUX, 16'hFF10);
      data_pointer_16 = 16'hFEFF;
      acc(msd_pkg::MODE_XDPTR, 8'h00, msd_pkg::TGT_EXT, 16'hFEFF);
      acc(msd_pkg::MODE_XPTR8, 8'h01, msd_pkg::TGT_AUX, 16'hFF08);
      acc(msd_pkg::MODE_DIRECT, 8'hB1, msd_pkg::TGT_SFR_STD, 16'h00B1, 9'h100);
      data_pointer_16 = 16'hFF10;
      acc(msd_pkg::MODE_XDPTR, 8'h00, msd_pkg::TGT_EXT, 16'hFF10);
      acc(msd_pkg::MODE_DIRECT, 8'h90, msd_pkg::TGT_SFR_STD, 16'h0090);
      @(negedge ref_clk);
      rq = '{1'b1, msd_pkg::msd_mode_e'(3'h7), 8'h00, 1'b0, 8'h00};
      @(negedge ref_clk);
      rq.valid = 1'b0;
      chk("rsp_valid", {15'h0, rsp.valid}, 16'h0000);
      acc(msd_pkg::MODE_DIRECT, 8'hB1, msd_pkg::TGT_SFR_STD, 16'h00B1, 9'h103);
      resetn = 1'b0;
      repeat (2) @(negedge ref_clk);
      resetn = 1'b1;
      acc(msd_pkg::MODE_DIRECT, 8'h90, msd_pkg::TGT_SFR_STD, 16'h0090);
      acc(msd_pkg::MODE_DIRECT, 8'hB1, msd_pkg::TGT_SFR_STD, 16'h00B1);
      chk("system_control", {7'h0, hit, rd}, 16'h0182);
      close_out();
   end
endmodule : testbench
